// File: spf_consts.vh
// Purpose: shared constants of the serial flash command block
// Assumes: included by bare name from the command block design file only
// Notes: opcodes are compared after masking the don't-care bit
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH

// Opcodes, bit 3 masked off
`define SPF_OP_MASK 8'hF7
`define SPF_OP_SET_LATCH 8'h06
`define SPF_OP_CLR_LATCH 8'h04
`define SPF_OP_STAT_RD 8'h05
`define SPF_OP_STAT_WR 8'h01
`define SPF_OP_ARRAY_RD 8'h03
`define SPF_OP_PAGE_PROG 8'h02

// Address layout
`define SPF_AW 17
`define SPF_A_TOP 16
`define SPF_A_QTR 15
`define SPF_ADDR_BYTES 2'h2
`define SPF_SMALL_MASK 17'h0_FFFF

// Status byte fields
`define SPF_SR_BUSY 0
`define SPF_SR_WEL 1
`define SPF_SR_BP_LO 2
`define SPF_SR_BP_HI 3
`define SPF_SR_PIN_PROTECT_ENABLE 7
`define SPF_SR_ALL_ONES 8'hFF

// Block protect levels
`define SPF_BP_QTR 2'h1
`define SPF_BP_HALF 2'h2
`define SPF_BP_ALL 2'h3

// Page and buffer shape
`define SPF_LAST_COL 8'hFF
`define SPF_BUF_W 25

// Timing
`define SPF_CLK_MHZ 50
`define SPF_SR_WRITE_NS 10000000
`define SPF_SR_WRITE_CYC (`SPF_SR_WRITE_NS * `SPF_CLK_MHZ / 1000)

`endif

// File: spf_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: synchronous active-high reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module spf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire reset,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // Two stages, reset to the idle level
  always @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule

// File: spf_buf.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: synchronous active-high reset
// Notes: outputs and in_ready all come from flops
`timescale 1ns/1ps
module spf_buf #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg out_valid_reg;
  reg [WIDTH-1:0] out_data_reg;
  reg skid_valid_reg;
  reg [WIDTH-1:0] skid_data_reg;
  wire take;
  wire give;

  assign in_ready = ~skid_valid_reg;
  assign take = in_valid & ~skid_valid_reg;
  assign give = out_valid_reg & out_ready;

  // Output stage refills from skid first, then from input
  always @(posedge clk_sys) begin
    if (reset) begin
      out_valid_reg <= 1'b0;
      skid_valid_reg <= 1'b0;
      out_data_reg <= {WIDTH{1'b0}};
      skid_data_reg <= {WIDTH{1'b0}};
    end else begin
      if (~out_valid_reg | give) begin
        if (skid_valid_reg) begin
          out_valid_reg <= 1'b1;
          out_data_reg <= skid_data_reg;
          skid_valid_reg <= take;
          skid_data_reg <= in_data;
        end else begin
          out_valid_reg <= take;
          out_data_reg <= in_data;
        end
      end else if (take) begin
        skid_valid_reg <= 1'b1;
        skid_data_reg <= in_data;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
endmodule

// File: spf_core.v
// Purpose: command logic of a small serial flash, SPI slave side
// Assumes: clk_sys well above serial clock; array behind plain ports
// Notes: program bytes collect in a page buffer, drain after deselect
// Behaviour
// - pin low and enable bit set means protected
// - pin high or enable clear means unprotected
// - protection blocks status writes and locked sectors
// - array write needs latch and unlocked sector
// - latch, then status write command and byte
// - while busy only status read is taken
// - latch clears when a write cycle ends
// - enable bit stays set while pin low
// - read command, address, data out MSB first
// - serial input ignored after read address
// - read address increments, wrapping at the top of each variant
// - programming starts on chip select rising
// - status bit 0 shows program in progress
// - page program wraps within page, overwrites
// - write without latch ignored until deselect
// - three address bytes, upper bits ignored
// - smaller variant with bit 16 set writes nothing
// - opcodes decoded with bit 3 don't-care
// - status byte layout of latch, busy, protect
// - protect levels per variant
// - deselected: no input taken, output released
`timescale 1ns/1ps
`include "spf_consts.vh"
module spf_core #(
  parameter LARGE = 1,
  parameter SR_WRITE_CYCLES = `SPF_SR_WRITE_CYC
) (
  input wire clk_sys,
  input wire reset,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  output wire so_out,
  output wire so_oe,
  output wire [16:0] mem_rd_addr,
  input wire [7:0] mem_rd_data,
  output wire mem_wr_valid,
  input wire mem_wr_ready,
  output wire [16:0] mem_wr_addr,
  output wire [7:0] mem_wr_data,
  output wire busy,
  output wire write_latch,
  output wire hw_protect
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_ADDR = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_SROUT = 3'h4;
  localparam [2:0] ST_SRIN = 3'h5;
  localparam [2:0] ST_PDATA = 3'h6;
  localparam [2:0] ST_IGNORE = 3'h7;

  // Locked-out test for one address
  function locked;
    input [16:0] addr;
    input [1:0] bp;
    begin
      if (bp == `SPF_BP_ALL)
        locked = 1'b1;
      else if (LARGE != 0 && bp == `SPF_BP_QTR)
        locked = addr[`SPF_A_TOP] & addr[`SPF_A_QTR];
      else if (LARGE != 0 && bp == `SPF_BP_HALF)
        locked = addr[`SPF_A_TOP];
      else
        locked = 1'b0;
    end
  endfunction

  // Byte may really be written
  function write_ok;
    input [16:0] addr;
    input [1:0] bp;
    begin
      write_ok = ~locked(addr, bp) &
        ((LARGE != 0) | ~addr[`SPF_A_TOP]);
    end
  endfunction

  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire wp_n_s;
  reg sck_d_reg;
  reg cs_d_reg;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg [7:0] in_sh_reg;
  reg [16:0] addr_acc_reg;
  reg [16:0] rd_addr_reg;
  reg [6:0] out_sh_reg;
  reg so_out_reg;
  reg so_oe_reg;
  reg is_prog_reg;
  reg wel_reg;
  reg pin_protect_enable_reg;
  reg [1:0] bp_reg;
  reg [7:0] sr_new_reg;
  reg sr_full_reg;
  reg sr_busy_reg;
  reg [31:0] sr_cnt_reg;
  reg prog_busy_reg;
  reg [8:0] page_reg;
  reg [7:0] col_reg;
  reg got_data_reg;
  reg [7:0] drain_idx_reg;
  reg drain_last_reg;
  reg [255:0] pg_valid_reg;
  reg [7:0] pg_data_reg [0:255];
  reg hw_prot_reg;
  reg busy_reg;

  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire selected;
  wire hw_prot_now;
  wire is_busy;
  wire [7:0] in_byte;
  wire [7:0] op;
  wire [16:0] new_addr;
  wire [16:0] next_rd;
  wire [7:0] status_byte;
  wire [7:0] load_byte;
  wire [16:0] drain_addr;
  wire drain_ok;
  wire buf_in_valid;
  wire buf_in_ready;
  wire drain_step;
  wire buf_empty;

  // Pins cross into clk_sys
  spf_sync #(.WIDTH(4), .INIT(4'h9)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .din({cs_n, sck, si, wp_n}),
    .dout({cs_n_s, sck_s, si_s, wp_n_s})
  );

  // Edge detection on synchronised pins
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign cs_fall = ~cs_n_s & cs_d_reg;
  assign cs_rise = cs_n_s & ~cs_d_reg;
  assign selected = ~cs_n_s;

  // Hardware protection and busy
  assign hw_prot_now = pin_protect_enable_reg & ~wp_n_s;
  assign is_busy = sr_busy_reg | prog_busy_reg;

  // Byte assembly and decode
  assign in_byte = {in_sh_reg[6:0], si_s};
  assign op = in_byte & `SPF_OP_MASK;
  assign new_addr = {addr_acc_reg[8:0], in_byte};
  assign next_rd = (LARGE != 0) ? rd_addr_reg + 17'h0_0001 :
    ((rd_addr_reg + 17'h0_0001) & `SPF_SMALL_MASK);

  // Status byte, all ones while a cycle runs
  assign status_byte = is_busy ? `SPF_SR_ALL_ONES :
    {pin_protect_enable_reg, 3'h0, bp_reg, wel_reg, 1'b0};
  assign load_byte = (state_reg == ST_RDATA) ? mem_rd_data : status_byte;

  // Page drain into the write buffer
  assign drain_addr = {page_reg, drain_idx_reg};
  assign drain_ok = write_ok(drain_addr, bp_reg);
  assign buf_in_valid = prog_busy_reg & ~drain_last_reg &
    pg_valid_reg[drain_idx_reg] & drain_ok;
  assign drain_step = prog_busy_reg & ~drain_last_reg &
    (~pg_valid_reg[drain_idx_reg] | ~drain_ok | buf_in_ready);
  assign buf_empty = ~mem_wr_valid & buf_in_ready;

  spf_buf #(.WIDTH(`SPF_BUF_W)) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({drain_addr, pg_data_reg[drain_idx_reg]}),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data({mem_wr_addr, mem_wr_data})
  );

  // Page buffer storage
  always @(posedge clk_sys) begin
    if (selected && sck_rise && bit_cnt_reg == 3'h7 &&
        state_reg == ST_PDATA) begin
      pg_data_reg[col_reg] <= in_byte;
    end
  end

  // Serial protocol and command sequencing
  always @(posedge clk_sys) begin
    if (reset) begin
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      in_sh_reg <= 8'h00;
      addr_acc_reg <= 17'h0_0000;
      rd_addr_reg <= 17'h0_0000;
      out_sh_reg <= 7'h00;
      so_out_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      is_prog_reg <= 1'b0;
      wel_reg <= 1'b0;
      pin_protect_enable_reg <= 1'b0;
      bp_reg <= 2'h0;
      sr_new_reg <= 8'h00;
      sr_full_reg <= 1'b0;
      sr_busy_reg <= 1'b0;
      sr_cnt_reg <= 32'h0000_0000;
      prog_busy_reg <= 1'b0;
      page_reg <= 9'h000;
      col_reg <= 8'h00;
      got_data_reg <= 1'b0;
      drain_idx_reg <= 8'h00;
      drain_last_reg <= 1'b0;
      pg_valid_reg <= {256{1'b0}};
      hw_prot_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      cs_d_reg <= cs_n_s;
      hw_prot_reg <= hw_prot_now;
      busy_reg <= is_busy;
      // Output driven only while selected in a read state
      so_oe_reg <= selected &
        (state_reg == ST_RDATA || state_reg == ST_SROUT);
      if (cs_fall) begin
        state_reg <= ST_CMD;
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 2'h0;
        sr_full_reg <= 1'b0;
        got_data_reg <= 1'b0;
      end else if (cs_rise) begin
        state_reg <= ST_IDLE;
        // Status write commits only if latch set and unprotected
        if (sr_full_reg && wel_reg && !hw_prot_now &&
            !is_busy) begin
          sr_busy_reg <= 1'b1;
          sr_cnt_reg <= 32'h0000_0000;
        end
        // Program starts on deselect at a byte boundary
        if (state_reg == ST_PDATA && got_data_reg &&
            bit_cnt_reg == 3'h0) begin
          prog_busy_reg <= 1'b1;
          drain_idx_reg <= 8'h00;
          drain_last_reg <= 1'b0;
        end
      end else if (selected && sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        in_sh_reg <= in_byte;
        if (bit_cnt_reg == 3'h7) begin
          case (state_reg)
            ST_CMD: begin
              if (is_busy && op != `SPF_OP_STAT_RD) begin
                state_reg <= ST_IGNORE;
              end else if (op == `SPF_OP_SET_LATCH) begin
                wel_reg <= 1'b1;
                state_reg <= ST_IGNORE;
              end else if (op == `SPF_OP_CLR_LATCH) begin
                wel_reg <= 1'b0;
                state_reg <= ST_IGNORE;
              end else if (op == `SPF_OP_STAT_RD) begin
                state_reg <= ST_SROUT;
              end else if (op == `SPF_OP_STAT_WR) begin
                state_reg <= wel_reg ? ST_SRIN : ST_IGNORE;
              end else if (op == `SPF_OP_ARRAY_RD) begin
                state_reg <= ST_ADDR;
                is_prog_reg <= 1'b0;
              end else if (op == `SPF_OP_PAGE_PROG && wel_reg) begin
                state_reg <= ST_ADDR;
                is_prog_reg <= 1'b1;
                pg_valid_reg <= {256{1'b0}};
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
            ST_ADDR: begin
              addr_acc_reg <= new_addr;
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
              if (byte_cnt_reg == `SPF_ADDR_BYTES) begin
                if (is_prog_reg) begin
                  page_reg <= new_addr[16:8];
                  col_reg <= new_addr[7:0];
                  state_reg <= ST_PDATA;
                end else begin
                  rd_addr_reg <= new_addr;
                  state_reg <= ST_RDATA;
                end
              end
            end
            ST_SRIN: begin
              sr_new_reg <= in_byte;
              sr_full_reg <= 1'b1;
              state_reg <= ST_IGNORE;
            end
            ST_PDATA: begin
              pg_valid_reg[col_reg] <= 1'b1;
              col_reg <= col_reg + 8'h01;
              got_data_reg <= 1'b1;
            end
            ST_RDATA: begin
              rd_addr_reg <= next_rd;
            end
            default: begin
              state_reg <= state_reg;
            end
          endcase
        end
      end else if (selected && sck_fall &&
          (state_reg == ST_RDATA || state_reg == ST_SROUT)) begin
        // Load a new byte at the boundary, else shift
        if (bit_cnt_reg == 3'h0) begin
          so_out_reg <= load_byte[7];
          out_sh_reg <= load_byte[6:0];
        end else begin
          so_out_reg <= out_sh_reg[6];
          out_sh_reg <= {out_sh_reg[5:0], 1'b0};
        end
      end
      // Self-timed status write cycle
      if (sr_busy_reg) begin
        sr_cnt_reg <= sr_cnt_reg + 32'h0000_0001;
        if (sr_cnt_reg == SR_WRITE_CYCLES - 1) begin
          sr_busy_reg <= 1'b0;
          wel_reg <= 1'b0;
          pin_protect_enable_reg <= sr_new_reg[`SPF_SR_PIN_PROTECT_ENABLE];
          bp_reg <= {sr_new_reg[`SPF_SR_BP_HI],
            sr_new_reg[`SPF_SR_BP_LO]};
        end
      end
      // Program cycle walks the page and waits for the buffer
      if (drain_step) begin
        drain_idx_reg <= drain_idx_reg + 8'h01;
        if (drain_idx_reg == `SPF_LAST_COL)
          drain_last_reg <= 1'b1;
      end
      if (prog_busy_reg && drain_last_reg && buf_empty) begin
        prog_busy_reg <= 1'b0;
        wel_reg <= 1'b0;
      end
    end
  end

  assign so_out = so_out_reg;
  assign so_oe = so_oe_reg;
  assign mem_rd_addr = rd_addr_reg;
  assign busy = busy_reg;
  assign write_latch = wel_reg;
  assign hw_protect = hw_prot_reg;
endmodule

// File: spf_core_sva.sv
// Purpose: port-level checks of the serial flash command block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every spf_core instance
`timescale 1ns/1ps
module spf_core_sva #(
  parameter LARGE = 1,
  parameter SR_WRITE_CYCLES = 20
) (
  input wire clk_sys,
  input wire reset,
  input wire cs_n,
  input wire wp_n,
  input wire so_oe,
  input wire [16:0] mem_rd_addr,
  input wire mem_wr_valid,
  input wire mem_wr_ready,
  input wire [16:0] mem_wr_addr,
  input wire [7:0] mem_wr_data,
  input wire busy,
  input wire write_latch,
  input wire hw_protect
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Read counter wraps at the top of the variant
  wire [16:0] top_mask = (LARGE != 0) ? 17'h1_FFFF : 17'h0_FFFF;
  // Pin levels held past the sync chain
  sequence s_desel;
    cs_n [*6];
  endsequence
  sequence s_pin_high;
    wp_n [*5];
  endsequence
  AST_HWP_OFF: assert property (s_pin_high |-> !hw_protect)
    else $error("protection active while pin high");
  AST_SO_RELEASE: assert property (s_desel |-> !so_oe)
    else $error("output driven while deselected");
  AST_LATCH_CLR: assert property ($fell(busy) |-> !write_latch)
    else $error("latch still set after write cycle");
  AST_WR_IN_CYCLE: assert property (mem_wr_valid |-> busy && write_latch)
    else $error("array write outside a latched cycle");
  AST_START_DESEL: assert property ($rose(busy) |-> cs_n)
    else $error("cycle started while selected");
  AST_LATCH_IDLE: assert property ($rose(write_latch) |-> !busy)
    else $error("latch set during a write cycle");
  AST_WR_HOLD: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("array write dropped or changed while stalled");
  AST_RD_STEP: assert property (so_oe && $past(so_oe) && !cs_n &&
    $changed(mem_rd_addr) |->
    mem_rd_addr == (($past(mem_rd_addr) + 17'h0_0001) & top_mask))
    else $error("read address did not step by one");
endmodule

bind spf_core spf_core_sva #(
  .LARGE(LARGE),
  .SR_WRITE_CYCLES(SR_WRITE_CYCLES)
) spf_core_sva_inst (
  .clk_sys(clk_sys),
  .reset(reset),
  .cs_n(cs_n),
  .wp_n(wp_n),
  .so_oe(so_oe),
  .mem_rd_addr(mem_rd_addr),
  .mem_wr_valid(mem_wr_valid),
  .mem_wr_ready(mem_wr_ready),
  .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data),
  .busy(busy),
  .write_latch(write_latch),
  .hw_protect(hw_protect)
);

// File: spf_host.sv
// Purpose: SPI master model for the flash command block
// Assumes: mode 0 (serial clock idle low) by default, mode 3 after set_mode, 160 ns period
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
module spf_host (
  output reg cs_n,
  output reg sck,
  output reg si,
  input wire so_pin
);
  // Clock level between frames: low for mode 0, high for mode 3
  reg idle_hi = 1'b0;
  // Idle pin levels
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Select and settle before the first bit
  task sel;
    begin
      cs_n = 1'b0;
      #80;
    end
  endtask
  // Change clock polarity while deselected
  task set_mode(input m);
    begin
      idle_hi = m;
      sck = m;
      #160;
    end
  endtask
  // Deselect 40 ns after the last bit, clock at its idle level
  task desel;
    begin
      #40 cs_n = 1'b1;
      si = ~si;
      #200;
    end
  endtask
  // One byte MSB first; set while low, sample at rise
  task xb(input [7:0] tx, output [7:0] rx);
    integer b;
    begin
      for (b = 7; b >= 0; b = b - 1) begin
        if (idle_hi) begin
          sck = 1'b0;
        end
        si = tx[b];
        #80 sck = 1'b1;
        rx[b] = so_pin;
        #80;
        if (!idle_hi) begin
          sck = 1'b0;
        end
      end
    end
  endtask
endmodule

// File: spf_core_tb.sv
// Purpose: self-checking bench of the flash command block
// Assumes: larger variant, short status write cycle
// Notes: reference array mirrors every write the rules allow
`timescale 1ns/1ps
module spf_core_tb;
  reg clk_sys, reset, wp_n;
  reg stall = 1'b0;
  reg mem_wr_ready = 1'b0;
  wire cs_n, sck, si, so_out, so_oe, mem_wr_valid;
  wire busy, write_latch, hw_protect;
  wire [16:0] mem_rd_addr, mem_wr_addr;
  wire [7:0] mem_wr_data;
  reg [7:0] mem [0:131071];
  reg [7:0] ref_mem [0:131071];
  reg [31:0] seed;
  reg [31:0] rdy_seed = 32'h3ad9_ca71;
  reg [23:0] lk;
  reg [7:0] rx;
  integer err_count, compares, i;
  // Released line shows the inverse of the last bit driven
  wire so_pin = (so_oe === 1'b1) ? so_out : ~so_out;
  spf_core #(.LARGE(1), .SR_WRITE_CYCLES(20)) spf_core_inst (
    .clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .sck(sck),
    .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem[mem_rd_addr]),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .busy(busy), .write_latch(write_latch), .hw_protect(hw_protect));
  spf_host host (.cs_n(cs_n), .sck(sck), .si(si), .so_pin(so_pin));
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Array behind the write port, stalled at random
  always @(posedge clk_sys) begin
    if (mem_wr_valid && mem_wr_ready) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end
  always @(negedge clk_sys) begin
    rdy_seed <= lfsr_next(rdy_seed);
    mem_wr_ready <= !stall && rdy_seed[3];
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task cmd(input [7:0] op);
    begin
      host.sel;
      host.xb(op, rx);
      host.desel;
    end
  endtask
  // Status read, second byte compared
  task sr_rd(input [7:0] exp);
    begin
      host.sel;
      host.xb(8'h05, rx);
      host.xb(8'h00, rx);
      host.desel;
      chk(rx, exp);
    end
  endtask
  task srw(input [7:0] v);
    begin
      host.sel;
      host.xb(8'h01, rx);
      host.xb(v, rx);
      host.desel;
    end
  endtask
  // Opcode, then three address bytes
  task head(input [7:0] op, input [23:0] a);
    begin
      host.sel;
      host.xb(op, rx);
      host.xb(a[23:16], rx);
      host.xb(a[15:8], rx);
      host.xb(a[7:0], rx);
    end
  endtask
  // Program n random bytes; ok says whether they may land
  task prog(input [23:0] a, input integer n, input ok);
    integer k;
    reg [16:0] p;
    begin
      p = a[16:0];
      head(8'h0A, a);
      for (k = 0; k < n; k = k + 1) begin
        seed = lfsr_next(seed);
        host.xb(seed[7:0], rx);
        if (ok) begin
          ref_mem[p] = seed[7:0];
        end
        p[7:0] = p[7:0] + 8'h01;
      end
      host.desel;
    end
  endtask
  // Continuous read with noise on serial input
  task rd(input [23:0] a, input integer n);
    integer k;
    reg [16:0] p;
    begin
      p = a[16:0];
      head(8'h0B, a);
      for (k = 0; k < n; k = k + 1) begin
        seed = lfsr_next(seed);
        host.xb(seed[7:0], rx);
        chk(rx, ref_mem[p]);
        p = p + 17'h0_0001;
      end
      host.desel;
    end
  endtask
  task wait_idle;
    integer k;
    begin
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
        @(negedge clk_sys);
        k = k + 1;
      end
      if (k >= 5000) begin
        err_count = err_count + 1;
        $display("ERROR %0t write cycle never ended", $time);
        wrap_up;
      end
    end
  endtask
  initial begin
    reset = 1'b1;
    wp_n = 1'b1;
    seed = 32'h3ad9_ca71;
    err_count = 0;
    compares = 0;
    for (i = 0; i < 131072; i = i + 1) begin
      mem[i] = i[7:0] ^ i[15:8];
      ref_mem[i] = i[7:0] ^ i[15:8];
    end
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (6) @(negedge clk_sys);
    sr_rd(8'h00);
    prog(24'h00_0010, 1, 0);
    chk({7'h00, busy}, 8'h00);
    cmd(8'h0E);
    chk({7'h00, write_latch}, 8'h01);
    sr_rd(8'h02);
    stall = 1'b1;
    prog(24'hE1_00FE, 258, 1);
    sr_rd(8'hFF);
    srw(8'h8C);
    stall = 1'b0;
    wait_idle;
    sr_rd(8'h00);
    rd(24'h01_00FC, 8);
    rd(24'h01_FFFE, 3);
    rd(24'h00_FFFE, 2);
    cmd(8'h06);
    srw(8'h8C);
    wait_idle;
    sr_rd(8'h8C);
    wp_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({7'h00, hw_protect}, 8'h01);
    cmd(8'h06);
    srw(8'h00);
    wait_idle;
    cmd(8'h04);
    sr_rd(8'h8C);
    cmd(8'h06);
    prog(24'h00_0020, 2, 0);
    wait_idle;
    rd(24'h00_0020, 2);
    wp_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({7'h00, hw_protect}, 8'h00);
    // Each protect level: first locked byte and the one below
    for (i = 1; i < 4; i = i + 1) begin
      cmd(8'h06);
      srw({4'h0, i[1:0], 2'b00});
      wait_idle;
      sr_rd({4'h0, i[1:0], 2'b00});
      lk = (i == 1) ? 24'h01_8000 : (i == 2) ? 24'h01_0000 : 24'h00_0000;
      cmd(8'h06);
      prog(lk, 1, 0);
      wait_idle;
      cmd(8'h06);
      prog(lk - 24'h00_0001, 1, i != 3);
      wait_idle;
      rd(lk - 24'h00_0001, 2);
    end
    // Latch before the erase opcode, then the link in mode 3
    cmd(8'h06);
    head(8'h52, 24'h01_0000);
    host.desel;
    cmd(8'h04);
    host.set_mode(1'b1);
    sr_rd(8'h0C);
    rd(24'h01_00FC, 4);
    wrap_up;
  end
endmodule
